// file: logic/icc_pkg.sv
/*
  Package for the instruction class checker: opcode values, field positions,
  vector offset and register file sizes.
  Assumes a 32-bit bit numbering where word bit 31 is the MSB and opcode bit 0 is word bit 26.
*/
package icc_pkg;
  localparam int ICC_WORD_BITS = 32;
  localparam int ICC_WORD_BYTES = 4;
  localparam int ICC_REGFILE_ENTRIES = 32;
  localparam int ICC_OPC_MSB = 31;
  localparam int ICC_OPC_LSB = 26;
  localparam int ICC_XO_MSB = 10;
  localparam int ICC_XO_LSB = 1;
  localparam int ICC_AXO_MSB = 5;
  localparam int ICC_AXO_LSB = 1;
  localparam logic [31:0] ICC_PROGRAM_VECTOR = 32'h00000700;
  localparam logic [63:0] ICC_UNDEF_OPC_MAP = 64'h3300_0000_0040_0262;
  localparam logic [63:0] ICC_WIDE_OPC_MAP = 64'h4400_0000_4000_0004;
  localparam logic [5:0] ICC_OPC_SC = 6'h11;
  localparam logic [5:0] ICC_OPC_CR = 6'h13;
  localparam logic [5:0] ICC_OPC_EXT = 6'h1F;
  localparam logic [5:0] ICC_OPC_FPS = 6'h3B;
  localparam logic [5:0] ICC_OPC_FPD = 6'h3F;
  localparam logic [5:0] ICC_OPC_VEC = 6'h04;
  localparam logic [4:0] ICC_AXO_FSQRT = 5'h16;
  localparam logic [9:0] ICC_XO_TLBIA = 10'h172;
  localparam logic [1:0] ICC_ADDR_ALIGN = 2'h0;
  typedef enum logic [1:0] {
    ICC_CLASS_DEFINED = 2'b00,
    ICC_CLASS_ILLEGAL = 2'b01,
    ICC_CLASS_RESERVED = 2'b10
  } icc_class_t;
endpackage : icc_pkg

// file: logic/icc_xo_table.sv
/*
  Extended opcode lookup for the opcode groups that carry one.
  Assumes the caller only trusts the answer for those groups.
*/
`timescale 1ns/1ns
`default_nettype none
module icc_xo_table
  import icc_pkg::*;
(
  input wire logic [5:0] opc,
  input wire logic [9:0] xo,
  output logic assigned,
  output logic optional_absent
);
  logic [4:0] axo;
  assign axo = xo[4:0];
  always_comb begin
    assigned = 1'b0;
    optional_absent = 1'b0;
    case (opc)
      ICC_OPC_SC: assigned = (xo[0] == 1'b1);
      ICC_OPC_CR: begin
        case (xo)
          10'h000, 10'h010, 10'h021, 10'h032, 10'h081, 10'h096, 10'h0C1, 10'h0E1,
          10'h101, 10'h121, 10'h1A1, 10'h1C1, 10'h210: assigned = 1'b1;
          default: assigned = 1'b0;
        endcase
      end
      ICC_OPC_EXT: begin
        // Optional translation invalidate-all is trapped for software.
        optional_absent = (xo == ICC_XO_TLBIA);
        assigned = !optional_absent && (xo[9:0] != 10'h3FF);
      end
      ICC_OPC_FPS, ICC_OPC_FPD: begin
        // Square root in both precisions is left to software emulation.
        optional_absent = (axo == ICC_AXO_FSQRT);
        assigned = !optional_absent && (axo >= 5'h12);
        // Double-precision move and status forms use the whole field below the A-form range.
        if (opc == ICC_OPC_FPD && axo < 5'h12) begin
          case (xo)
            10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020, 10'h026, 10'h028, 10'h040,
            10'h046, 10'h048, 10'h086, 10'h088, 10'h108, 10'h247, 10'h2C7: assigned = 1'b1;
            default: assigned = 1'b0;
          endcase
        end
      end
      default: assigned = 1'b0;
    endcase
  end
endmodule : icc_xo_table
`default_nettype wire

// file: logic/icc_checker.sv
/*
  Instruction class checker: classifies fetched words and raises the
  illegal-instruction program interrupt request with its vector.
  Assumes fetch presents one word per valid cycle and exception logic
  suppresses writeback while the illegal flag is up.
*/
// Operation
// - Classify word as defined, illegal, reserved.
// - Undefined primary opcodes are illegal, trap.
// - Sixty-four-bit primary opcodes are illegal.
// - Unassigned extended opcodes are illegal.
// - All-zero word is always illegal.
// - Zero opcode with nonzero rest is reserved.
// - Unimplemented reserved instructions trap as illegal.
// - Square roots and invalidate-all trap.
// - Trap goes to fixed program vector.
// - All other 32-bit instructions are supported.
// - Every vector instruction is implemented.
// - Reserved-field misuse never raises privilege.
// - Instructions are word-sized and word-aligned.
// - Three register files of 32 entries.
// - Arithmetic never touches memory directly.
`timescale 1ns/1ns
`default_nettype none
module icc_checker
  import icc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_WORD,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic USER_MODE,
  input wire logic IS_ARITH,
  input wire logic IS_MEMOP,
  output logic OUT_VALID,
  output logic [1:0] OUT_CLASS,
  output logic OUT_ILLEGAL,
  output logic OUT_MISALIGNED,
  output logic OUT_COMMIT,
  output logic OUT_MEM_ALLOWED,
  output logic OUT_PRIV_ESCALATE,
  output logic [31:0] OUT_VECTOR,
  output logic [4:0] OUT_REGFILE_ADDR_BITS
);
  logic [5:0] opc;
  logic [9:0] xo;
  logic xo_assigned;
  logic xo_optional_absent;
  logic has_xo;
  logic next_illegal;
  logic next_misaligned;
  icc_class_t next_class;

  assign opc = FETCH_WORD[ICC_OPC_MSB:ICC_OPC_LSB];
  assign xo = FETCH_WORD[ICC_XO_MSB:ICC_XO_LSB];
  assign has_xo = (opc == ICC_OPC_SC) || (opc == ICC_OPC_CR) || (opc == ICC_OPC_EXT) ||
                  (opc == ICC_OPC_FPS) || (opc == ICC_OPC_FPD);

  icc_xo_table u_xo_table (
    .opc(opc),
    .xo(xo),
    .assigned(xo_assigned),
    .optional_absent(xo_optional_absent)
  );

  // The zero word is tested first so it can never fall into the reserved case.
  always_comb begin
    next_class = ICC_CLASS_DEFINED;
    if (FETCH_WORD == 32'h00000000) begin
      next_class = ICC_CLASS_ILLEGAL;
    end else if (opc == 6'h00) begin
      next_class = ICC_CLASS_RESERVED;
    end else if (ICC_UNDEF_OPC_MAP[opc]) begin
      next_class = ICC_CLASS_ILLEGAL;
    end else if (ICC_WIDE_OPC_MAP[opc]) begin
      next_class = ICC_CLASS_ILLEGAL;
    end else if (has_xo && !xo_assigned) begin
      next_class = ICC_CLASS_ILLEGAL;
    end
  end

  // No reserved-class instruction is implemented, so every one traps.
  assign next_illegal = (next_class != ICC_CLASS_DEFINED);
  assign next_misaligned = (FETCH_ADDR[1:0] != ICC_ADDR_ALIGN);

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OUT_VALID <= 1'b0;
      OUT_CLASS <= ICC_CLASS_DEFINED;
      OUT_ILLEGAL <= 1'b0;
      OUT_MISALIGNED <= 1'b0;
    end else if (CE) begin
      OUT_VALID <= FETCH_VALID;
      OUT_CLASS <= FETCH_VALID ? next_class : ICC_CLASS_DEFINED;
      OUT_ILLEGAL <= FETCH_VALID && next_illegal;
      OUT_MISALIGNED <= FETCH_VALID && next_misaligned;
    end
  end

  // Commit is withheld for a trapped word so writeback never sees it.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OUT_COMMIT <= 1'b0;
      OUT_MEM_ALLOWED <= 1'b0;
    end else if (CE) begin
      OUT_COMMIT <= FETCH_VALID && !next_illegal && !next_misaligned;
      OUT_MEM_ALLOWED <= FETCH_VALID && !next_illegal && IS_MEMOP && !IS_ARITH;
    end
  end

  // Decoding never asks for a state change; user mode can never be lifted here.
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OUT_PRIV_ESCALATE <= 1'b0;
    end else if (CE) begin
      OUT_PRIV_ESCALATE <= 1'b0 & USER_MODE;
    end
  end

  assign OUT_VECTOR = ICC_PROGRAM_VECTOR;
  assign OUT_REGFILE_ADDR_BITS = 5'($clog2(ICC_REGFILE_ENTRIES));

  AST_ZERO_ILLEGAL: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && FETCH_WORD == 32'h0 |=> OUT_ILLEGAL)
    else $error("zero word not illegal");
  AST_RESERVED_CLASS: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h00 && FETCH_WORD != 32'h0 |=> OUT_CLASS == ICC_CLASS_RESERVED)
    else $error("zero opcode not reserved");
  AST_UNDEF_OPC: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && (opc == 6'h01 || opc == 6'h05 || opc == 6'h06 || opc == 6'h09 ||
    opc == 6'h16 || opc == 6'h38 || opc == 6'h39 || opc == 6'h3C || opc == 6'h3D)
    |=> OUT_ILLEGAL)
    else $error("undefined opcode not illegal");
  AST_WIDE_OPC: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && (opc == 6'd2 || opc == 6'd30 || opc == 6'd58 || opc == 6'd62)
    |=> OUT_ILLEGAL)
    else $error("wide opcode not illegal");
  AST_RESERVED_TRAPS: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_VALID && OUT_CLASS == ICC_CLASS_RESERVED |-> OUT_ILLEGAL)
    else $error("reserved word did not trap");
  AST_SQRT_TRAP: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == ICC_OPC_FPD && xo[4:0] == ICC_AXO_FSQRT |=> OUT_ILLEGAL)
    else $error("square root not trapped");
  AST_NO_COMMIT: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_ILLEGAL |-> !OUT_COMMIT && !OUT_MEM_ALLOWED)
    else $error("trapped word committed");
  AST_DEFINED_COMMITS: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'd14 && FETCH_ADDR[1:0] == 2'b00 |=> OUT_COMMIT && !OUT_ILLEGAL)
    else $error("defined word refused");
  AST_ALIGN: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && FETCH_ADDR[1:0] != 2'b00 |=> OUT_MISALIGNED && !OUT_COMMIT)
    else $error("misaligned fetch committed");
  AST_NO_ESCALATE: assert property (@(posedge CLK) disable iff (!RESETN)
    !OUT_PRIV_ESCALATE)
    else $error("privilege raised");

  // These use fixed opcode values, not the package maps, so a bad map entry cannot hide.
  AST_ZERO_OPC_TRAPS: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h00 |=> OUT_ILLEGAL && !OUT_COMMIT)
    else $error("zero opcode word not trapped");
  AST_SC_FORM: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h11 && !FETCH_WORD[1] |=> OUT_ILLEGAL)
    else $error("bad call form not illegal");
  AST_SC_DEFINED: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h11 && FETCH_WORD[1] |=> !OUT_ILLEGAL)
    else $error("call form refused");
  AST_CR_UNASSIGNED: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h13 && xo == 10'h001 |=> OUT_ILLEGAL)
    else $error("unassigned flow opcode not illegal");
  AST_EXT_UNASSIGNED: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h1F && xo == 10'h3FF |=> OUT_ILLEGAL)
    else $error("unassigned extended opcode not illegal");
  AST_INVALIDATE_TRAP: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h1F && xo == 10'h172 |=> OUT_ILLEGAL)
    else $error("invalidate-all not trapped");
  AST_SQRTS_TRAP: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h3B && xo[4:0] == 5'h16 |=> OUT_ILLEGAL)
    else $error("single square root not trapped");
  AST_FMOVE_DEFINED: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h3F && xo == 10'h048 |=> !OUT_ILLEGAL)
    else $error("float move refused");
  AST_VECTOR_DEFINED: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h04 |=> OUT_CLASS == ICC_CLASS_DEFINED && !OUT_ILLEGAL)
    else $error("vector word refused");
  AST_VALID_FOLLOWS: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID |=> OUT_VALID)
    else $error("taken word not marked valid");
  AST_IDLE_QUIET: assert property (@(posedge CLK) disable iff (!RESETN)
    !OUT_VALID |-> OUT_CLASS == ICC_CLASS_DEFINED && !OUT_ILLEGAL && !OUT_COMMIT)
    else $error("idle slot shows a result");
  AST_ILLEGAL_TRAPS: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_CLASS == ICC_CLASS_ILLEGAL |-> OUT_ILLEGAL)
    else $error("illegal class did not trap");
  AST_DEFINED_QUIET: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_CLASS == ICC_CLASS_DEFINED |-> !OUT_ILLEGAL)
    else $error("defined class trapped");
  AST_TRAP_VECTOR: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_VECTOR == 32'h0000_0700)
    else $error("trap vector wrong");
  AST_REGFILE_SIZE: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_REGFILE_ADDR_BITS == 5'h05)
    else $error("register file size wrong");
  AST_ARITH_NO_MEM: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && IS_ARITH |=> !OUT_MEM_ALLOWED)
    else $error("arithmetic word given memory");
  AST_MEM_TAKEN: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_MEM_ALLOWED |-> OUT_VALID && !OUT_ILLEGAL)
    else $error("memory granted without a legal word");
  AST_MISALIGN_LEGAL: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && FETCH_VALID && opc == 6'h0E && FETCH_ADDR[1:0] != 2'h0 |=> !OUT_ILLEGAL)
    else $error("misaligned defined word called illegal");
  // A frozen stage must hold its results, or a stalled trap could be lost or repeated.
  AST_CE_FREEZE: assert property (@(posedge CLK) disable iff (!RESETN)
    !CE |=> $stable({OUT_VALID, OUT_CLASS, OUT_ILLEGAL, OUT_MISALIGNED}) &&
    $stable({OUT_COMMIT, OUT_MEM_ALLOWED}))
    else $error("outputs moved while frozen");
  AST_RESET_CLEARS: assert property (@(posedge CLK)
    !RESETN |=> !OUT_VALID && !OUT_ILLEGAL && !OUT_COMMIT && !OUT_MEM_ALLOWED)
    else $error("reset left a request up");
endmodule : icc_checker
`default_nettype wire

// file: testbench/icc_exc_model.sv
/*
  Exception-side partner: records the vector of each program interrupt request.
  Assumes the checker's outputs are registered on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module icc_exc_model
  import icc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic illegal,
  input wire logic [31:0] vector,
  output logic [31:0] last_vec
);
  // Only a raised request loads the vector, so a stale value shows a missed trap.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_vec <= 32'h0;
    end else if (illegal) begin
      last_vec <= vector;
    end
  end
endmodule : icc_exc_model
`default_nettype wire

// file: testbench/tb_instruction_class_checker.sv
/*
  Testbench for the instruction class checker.
  Assumes one word is presented per call and outputs settle one edge later.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_instruction_class_checker
  import icc_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic fv = 1'b0;
  logic [31:0] fw = 32'h0;
  logic [31:0] fa = 32'h0;
  logic um = 1'b0;
  logic ar = 1'b0;
  logic mo = 1'b0;
  logic o_val, o_ill, o_mis, o_com, o_mem, o_esc;
  logic [1:0] o_cls;
  logic [31:0] o_vec, last_vec;
  logic [4:0] o_rfb;
  int err_count = 0;
  int compares = 0;
  always #4 clk = ~clk;
  icc_checker dut_u (.CLK(clk), .RESETN(resetn), .CE(ce), .FETCH_VALID(fv), .FETCH_WORD(fw),
    .FETCH_ADDR(fa), .USER_MODE(um), .IS_ARITH(ar), .IS_MEMOP(mo), .OUT_VALID(o_val),
    .OUT_CLASS(o_cls), .OUT_ILLEGAL(o_ill), .OUT_MISALIGNED(o_mis), .OUT_COMMIT(o_com),
    .OUT_MEM_ALLOWED(o_mem), .OUT_PRIV_ESCALATE(o_esc), .OUT_VECTOR(o_vec),
    .OUT_REGFILE_ADDR_BITS(o_rfb));
  icc_exc_model exc_u (.clk(clk), .resetn(resetn), .illegal(o_ill), .vector(o_vec),
    .last_vec(last_vec));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic send(input logic [31:0] w, input logic [1:0] a, input logic [2:0] f);
    @(posedge clk);
    fv <= 1'b1;
    fw <= w;
    fa <= {30'h0, a};
    {um, ar, mo} <= f;
    @(posedge clk);
    @(negedge clk);
  endtask : send
  task automatic t_illegal();
    int ops[13] = '{1, 5, 6, 9, 22, 56, 57, 60, 61, 2, 30, 58, 62};
    foreach (ops[i]) begin
      send({ops[i][5:0], 26'h1}, 2'h0, 3'h0);
      chk(o_cls, ICC_CLASS_ILLEGAL);
      chk(o_com, 1'b0);
    end
    chk(last_vec, 32'h00000700);
    $display("test illegal opcodes done");
  endtask : t_illegal
  task automatic t_ext();
    logic [31:0] w[13] = '{32'h0, 32'h1, 32'hFC00002C, 32'hEC00002C, 32'h7C0002E4,
      32'h7C0007FE, 32'h38000000, 32'h10000000, 32'h7C000214, 32'h44000000, 32'h44000002,
      32'h4C000002, 32'hFC000090};
    logic [1:0] c[13] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0,
      2'h1, 2'h0};
    foreach (w[i]) begin
      send(w[i], 2'h0, 3'h0);
      chk(o_cls, c[i]);
      chk(o_ill, c[i] != 2'h0);
      chk(o_com, c[i] == 2'h0);
    end
    $display("test extended opcodes done");
  endtask : t_ext
  task automatic t_misc();
    send(32'h38000000, 2'h2, 3'h0);
    chk({o_mis, o_ill, o_com}, 3'h4);
    send(32'h80000000, 2'h0, 3'h1);
    chk(o_mem, 1'b1);
    send(32'h80000000, 2'h0, 3'h3);
    chk(o_mem, 1'b0);
    send(32'h7C000215, 2'h0, 3'h4);
    chk(o_esc, 1'b0);
    chk(o_rfb, 5'h5);
    // A frozen stage must not let the all-zero word through.
    @(posedge clk);
    ce <= 1'b0;
    send(32'h0, 2'h0, 3'h0);
    chk(o_ill, 1'b0);
    chk(o_val, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk(o_ill, 1'b1);
    @(posedge clk);
    fv <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({o_val, o_cls, o_ill}, 4'h0);
    $display("test misc done");
  endtask : t_misc
  task automatic give_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(negedge clk);
    chk(o_val, 1'b0);
    t_illegal();
    t_ext();
    t_misc();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : tb_instruction_class_checker
`default_nettype wire
